// File: hdl/ds3_rx_status_regs.vh
// register indices, field positions and reset values for the receive status latch block
`ifndef DS3_RX_STATUS_REGS_VH
`define DS3_RX_STATUS_REGS_VH

// register indices; byte address = port * 256 + index * 4
`define IDX_RX_CONTROL 6'h20
`define IDX_COUNT_NONZERO 6'h26
`define IDX_LATCH_A 6'h28
`define IDX_LATCH_B 6'h2a
`define IDX_IRQ_EN_A 6'h2c
`define IDX_IRQ_EN_B 6'h2e
`define IDX_FRAMER_MODE 6'h3c
`define IDX_GLOBAL_PORT_EN 6'h00

// address fields
`define ADDR_W 12
`define ADDR_IDX_LSB 2
`define ADDR_BLK_LSB 8
`define BLK_GLOBAL 4'h4

// field positions
`define FSEL_LSB 8
`define M23_MODE_BIT 0
`define FMT_MISMATCH_BIT 11
`define ALIGN_CHANGE_BIT 5
`define OOF_BIT 1

// implemented bits of each register, toggle-set bits of latch a and latch b bits held zero in m23 mode
`define MASK_LATCH_A 16'h0fff
`define MASK_LATCH_B 16'h0f0f
`define MASK_LATCH_A_TOGGLE 16'h07df
`define MASK_M23_FORCED 16'h0c0c
`define MASK_RX_CONTROL 16'h0300
`define MASK_FRAMER_MODE 16'h0001

// reset values
`define RST_IRQ_EN 16'h0000
`define RST_RX_CONTROL 16'h0000
`define RST_FRAMER_MODE 16'h0000
`define RST_GLOBAL_EN 4'h0

// framing error type select encodings
`define FSEL_OOF 2'b00
`define FSEL_MF 2'b01
`define FSEL_F 2'b10
`define FSEL_M 2'b11

// axi responses
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// File: hdl/sticky_bits.v
// vector of write-one-to-clear latch bits where a set beats a clear
`timescale 1ns/1ps
module sticky_bits #(
    parameter W = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [W-1:0] set,
    input wire [W-1:0] clr,
    input wire [W-1:0] force_zero,
    output reg [W-1:0] q
);
    // held until cleared by a one; new event in the clear cycle survives
    wire [W-1:0] q_nxt = ((q & ~clr) | set) & ~force_zero;

    always @(posedge aclk) begin
        if (!aresetn) begin
            q <= {W{1'b0}};
        end else begin
            q <= q_nxt;
        end
    end
endmodule // sticky_bits

// File: hdl/axil_slave.v
// axi4-lite slave front end producing one-cycle write strobes and read lookups
`timescale 1ns/1ps
`include "ds3_rx_status_regs.vh"
module axil_slave #(
    parameter AW = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_en,
    output reg [AW-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_err,
    output wire [AW-1:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_err
);
    reg aw_full_r;
    reg w_full_r;

    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign wr_en = aw_full_r && w_full_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr = s_axi_araddr;

    // write side: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wr_addr <= {AW{1'b0}};
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_r) begin
                aw_full_r <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_r) begin
                w_full_r <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? `RESP_DECERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read side: data registered on the same edge that takes the address, valid the next cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `RESP_DECERR : `RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // axil_slave

// File: hdl/ds3_rx_status_latch_irq.v
// per-port ds3 receive status latches, count-nonzero flags and port interrupt requests
// Overview of operation
// - c parity nonzero flag is one when its count is nonzero, zero in m23 mode.
// - far end nonzero flag is one when its count is nonzero, zero in m23 mode.
// - p parity nonzero flag is one exactly while its count is nonzero.
// - framing nonzero flag is one while framing count is nonzero; type select picks events.
// - format mismatch latch sets only on a rising live mismatch.
// - each status change latch sets when its live bit toggles either way.
// - alignment change latch sets when framing counters reload with a new alignment.
// - c parity error latch sets per error and is held zero in m23 mode.
// - far end block error latch sets per error and is held zero in m23 mode.
// - p parity error latch sets on every detected p parity error.
// - framing error latch sets on each framing event of the selected type.
// - c parity count latch sets on rising nonzero flag, held zero in m23.
// - far end count latch sets on rising nonzero flag, held zero in m23.
// - p parity and framing count latches set on rising nonzero flags.
// - interrupt needs latch set, own enable set and the port global enable set.
// - enable bits mean one enabled, zero disabled, and all reset to zero.
// - first enable register bits line up with first latch register bits.
// - second enable bit 11 gates c parity error latch, bits 3..0 the counts.
// - type select 00 oof, 01 m and f bits, 10 f bits, 11 m bits.
// - live format mismatch when configured format differs from incoming format.
`timescale 1ns/1ps
`include "ds3_rx_status_regs.vh"
module ds3_rx_status_latch_irq #(
    parameter NUM_PORTS = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NUM_PORTS-1:0] application_channel_live,
    input wire [NUM_PORTS-1:0] idle_live,
    input wire [NUM_PORTS-1:0] unframed_all_ones_live,
    input wire [NUM_PORTS-1:0] multiframe_loss_live,
    input wire [NUM_PORTS-1:0] severe_frame_error_live,
    input wire [NUM_PORTS-1:0] frame_loss_live,
    input wire [NUM_PORTS-1:0] remote_alarm_live,
    input wire [NUM_PORTS-1:0] alarm_indication_live,
    input wire [NUM_PORTS-1:0] out_of_frame_live,
    input wire [NUM_PORTS-1:0] signal_absent_live,
    input wire [NUM_PORTS-1:0] alignment_reload_new,
    input wire [NUM_PORTS-1:0] c_parity_error_pulse,
    input wire [NUM_PORTS-1:0] far_end_block_error_pulse,
    input wire [NUM_PORTS-1:0] p_parity_error_pulse,
    input wire [NUM_PORTS-1:0] m_bit_error_pulse,
    input wire [NUM_PORTS-1:0] f_bit_error_pulse,
    input wire [16*NUM_PORTS-1:0] c_parity_count,
    input wire [16*NUM_PORTS-1:0] far_end_count,
    input wire [16*NUM_PORTS-1:0] p_parity_count,
    input wire [16*NUM_PORTS-1:0] framing_count,
    output wire [NUM_PORTS-1:0] m23_mode,
    output wire [2*NUM_PORTS-1:0] framing_error_type_select,
    output wire [NUM_PORTS-1:0] format_mismatch_live,
    output wire [NUM_PORTS-1:0] framing_event,
    output wire [NUM_PORTS-1:0] port_irq
);
    wire wr_en;
    wire [`ADDR_W-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [`ADDR_W-1:0] rd_addr;
    reg [31:0] rd_data;
    reg rd_err;
    reg wr_err;
    reg [NUM_PORTS-1:0] global_port_status_irq_enable;
    wire [16*NUM_PORTS-1:0] port_rd_flat;
    wire [NUM_PORTS-1:0] port_rd_known;

    // bytes 0 and 1 of the write data, gated by their strobes
    function [15:0] lane_mask;
        input [3:0] strb;
        begin
            lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    // merge a write into a plain read/write register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        input [15:0] mask;
        reg [15:0] lm;
        begin
            lm = lane_mask(strb) & mask;
            merge16 = (old & ~lm) | (data[15:0] & lm);
        end
    endfunction

    // register index held at one port block
    function known_idx;
        input [5:0] idx;
        begin
            case (idx)
                `IDX_RX_CONTROL: known_idx = 1'b1;
                `IDX_COUNT_NONZERO: known_idx = 1'b1;
                `IDX_LATCH_A: known_idx = 1'b1;
                `IDX_LATCH_B: known_idx = 1'b1;
                `IDX_IRQ_EN_A: known_idx = 1'b1;
                `IDX_IRQ_EN_B: known_idx = 1'b1;
                `IDX_FRAMER_MODE: known_idx = 1'b1;
                default: known_idx = 1'b0;
            endcase
        end
    endfunction

    // selected framing error event
    function pick_framing;
        input [1:0] sel;
        input oof_occ;
        input m_err;
        input f_err;
        begin
            case (sel)
                `FSEL_OOF: pick_framing = oof_occ;
                `FSEL_MF: pick_framing = m_err | f_err;
                `FSEL_F: pick_framing = f_err;
                `FSEL_M: pick_framing = m_err;
                default: pick_framing = 1'b0;
            endcase
        end
    endfunction

    axil_slave #(
        .AW(`ADDR_W)
    ) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    wire [3:0] wr_blk = wr_addr[`ADDR_W-1:`ADDR_BLK_LSB];
    wire [5:0] wr_idx = wr_addr[`ADDR_BLK_LSB-1:`ADDR_IDX_LSB];
    wire [3:0] rd_blk = rd_addr[`ADDR_W-1:`ADDR_BLK_LSB];
    wire [5:0] rd_idx = rd_addr[`ADDR_BLK_LSB-1:`ADDR_IDX_LSB];
    wire wr_global = wr_en && (wr_blk == `BLK_GLOBAL) && (wr_idx == `IDX_GLOBAL_PORT_EN);

    // global per-port enable register
    always @(posedge aclk) begin
        if (!aresetn) begin
            global_port_status_irq_enable <= `RST_GLOBAL_EN;
        end else if (wr_global && wr_strb[0]) begin
            global_port_status_irq_enable <= wr_data[NUM_PORTS-1:0];
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            reg [15:0] rx_control_r;
            reg [15:0] framer_mode_r;
            reg [15:0] irq_en_a_r;
            reg [15:0] irq_en_b_r;
            reg [11:0] live_prev_r;
            reg [3:0] nz_prev_r;
            reg primed_r;
            wire [15:0] latch_a;
            wire [15:0] latch_b;
            wire [11:0] live;
            wire [3:0] nz;
            wire [3:0] nz_rise;
            wire [15:0] set_a;
            wire [15:0] set_b;
            wire [15:0] clr_a;
            wire [15:0] clr_b;
            wire [15:0] force_b;
            wire [15:0] nz_status;
            wire oof_occ;
            wire m23;
            wire [1:0] fsel;
            wire hit;
            reg [15:0] rd_val;

            assign m23 = framer_mode_r[`M23_MODE_BIT];
            assign fsel = rx_control_r[`FSEL_LSB+1:`FSEL_LSB];
            assign hit = wr_en && (wr_blk == p);

            // configured c-bit is m23 low; incoming c-bit is channel high
            assign format_mismatch_live[p] = (m23 == application_channel_live[p]);

            assign live = {format_mismatch_live[p], application_channel_live[p],
                idle_live[p], unframed_all_ones_live[p], multiframe_loss_live[p],
                severe_frame_error_live[p], 1'b0, frame_loss_live[p],
                remote_alarm_live[p], alarm_indication_live[p],
                out_of_frame_live[p], signal_absent_live[p]};

            assign nz[3] = (c_parity_count[16*p +: 16] != 16'h0000) && !m23;
            assign nz[2] = (far_end_count[16*p +: 16] != 16'h0000) && !m23;
            assign nz[1] = (p_parity_count[16*p +: 16] != 16'h0000);
            assign nz[0] = (framing_count[16*p +: 16] != 16'h0000);
            assign nz_status = {12'h000, nz};
            assign nz_rise = nz & ~nz_prev_r & {4{primed_r}};

            assign oof_occ = out_of_frame_live[p] & ~live_prev_r[`OOF_BIT] & primed_r;
            assign framing_event[p] = pick_framing(fsel, oof_occ,
                m_bit_error_pulse[p], f_bit_error_pulse[p]);

            // first cycle after reset only records the live levels
            always @(posedge aclk) begin
                if (!aresetn) begin
                    live_prev_r <= 12'h000;
                    nz_prev_r <= 4'h0;
                    primed_r <= 1'b0;
                end else begin
                    live_prev_r <= live;
                    nz_prev_r <= nz;
                    primed_r <= 1'b1;
                end
            end

            assign set_a[15:12] = 4'h0;
            assign set_a[`FMT_MISMATCH_BIT] = live[11] & ~live_prev_r[11] & primed_r;
            assign set_a[10:6] = (live[10:6] ^ live_prev_r[10:6]) & {5{primed_r}};
            assign set_a[`ALIGN_CHANGE_BIT] = alignment_reload_new[p];
            assign set_a[4:0] = (live[4:0] ^ live_prev_r[4:0]) & {5{primed_r}};

            assign set_b[15:12] = 4'h0;
            assign set_b[11] = c_parity_error_pulse[p];
            assign set_b[10] = far_end_block_error_pulse[p];
            assign set_b[9] = p_parity_error_pulse[p];
            assign set_b[8] = framing_event[p];
            assign set_b[7:4] = 4'h0;
            assign set_b[3:2] = nz_rise[3:2];
            assign set_b[1:0] = nz_rise[1:0];
            assign force_b = m23 ? `MASK_M23_FORCED : 16'h0000;

            // write-one-to-clear, zeros leave bits alone
            assign clr_a = (hit && wr_idx == `IDX_LATCH_A) ?
                (wr_data[15:0] & lane_mask(wr_strb)) : 16'h0000;
            assign clr_b = (hit && wr_idx == `IDX_LATCH_B) ?
                (wr_data[15:0] & lane_mask(wr_strb)) : 16'h0000;

            sticky_bits #(
                .W(16)
            ) u_latch_a (
                .aclk(aclk),
                .aresetn(aresetn),
                .set(set_a & `MASK_LATCH_A),
                .clr(clr_a),
                .force_zero(~`MASK_LATCH_A),
                .q(latch_a)
            );

            sticky_bits #(
                .W(16)
            ) u_latch_b (
                .aclk(aclk),
                .aresetn(aresetn),
                .set(set_b & `MASK_LATCH_B),
                .clr(clr_b),
                .force_zero(force_b | ~`MASK_LATCH_B),
                .q(latch_b)
            );

            // software registers of this port
            always @(posedge aclk) begin
                if (!aresetn) begin
                    rx_control_r <= `RST_RX_CONTROL;
                    framer_mode_r <= `RST_FRAMER_MODE;
                    irq_en_a_r <= `RST_IRQ_EN;
                    irq_en_b_r <= `RST_IRQ_EN;
                end else if (hit) begin
                    case (wr_idx)
                        `IDX_RX_CONTROL: begin
                            rx_control_r <= merge16(rx_control_r, wr_data, wr_strb,
                                `MASK_RX_CONTROL);
                        end
                        `IDX_FRAMER_MODE: begin
                            framer_mode_r <= merge16(framer_mode_r, wr_data, wr_strb,
                                `MASK_FRAMER_MODE);
                        end
                        `IDX_IRQ_EN_A: begin
                            irq_en_a_r <= merge16(irq_en_a_r, wr_data, wr_strb,
                                `MASK_LATCH_A);
                        end
                        `IDX_IRQ_EN_B: begin
                            irq_en_b_r <= merge16(irq_en_b_r, wr_data, wr_strb,
                                `MASK_LATCH_B);
                        end
                        default: rx_control_r <= rx_control_r;
                    endcase
                end
            end

            // enabled latched bits, or-ed, gated by this port's global enable
            assign port_irq[p] = global_port_status_irq_enable[p] &&
                (|(latch_a & irq_en_a_r) || |(latch_b & irq_en_b_r));

            assign m23_mode[p] = m23;
            assign framing_error_type_select[2*p +: 2] = fsel;

            always @* begin
                case (rd_idx)
                    `IDX_RX_CONTROL: rd_val = rx_control_r;
                    `IDX_COUNT_NONZERO: rd_val = nz_status;
                    `IDX_LATCH_A: rd_val = latch_a;
                    `IDX_LATCH_B: rd_val = latch_b;
                    `IDX_IRQ_EN_A: rd_val = irq_en_a_r;
                    `IDX_IRQ_EN_B: rd_val = irq_en_b_r;
                    `IDX_FRAMER_MODE: rd_val = framer_mode_r;
                    default: rd_val = 16'h0000;
                endcase
            end
            assign port_rd_flat[16*p +: 16] = rd_val;
            assign port_rd_known[p] = known_idx(rd_idx);
        end
    endgenerate

    // read mux and unmapped answers
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b1;
        if (rd_blk == `BLK_GLOBAL) begin
            if (rd_idx == `IDX_GLOBAL_PORT_EN) begin
                rd_data[NUM_PORTS-1:0] = global_port_status_irq_enable;
                rd_err = 1'b0;
            end
        end else if (rd_blk < NUM_PORTS) begin
            rd_data[15:0] = port_rd_flat[16*rd_blk[1:0] +: 16];
            rd_err = !port_rd_known[rd_blk[1:0]];
        end
    end

    always @* begin
        wr_err = 1'b1;
        if (wr_blk == `BLK_GLOBAL) begin
            wr_err = (wr_idx != `IDX_GLOBAL_PORT_EN);
        end else if (wr_blk < NUM_PORTS) begin
            wr_err = !known_idx(wr_idx);
        end
    end
endmodule // ds3_rx_status_latch_irq

// File: dv/ds3_rx_status_sva.sv
// port-level checks for the receive status latch block
`timescale 1ns/1ps
module ds3_rx_status_sva #(
    parameter NUM_PORTS = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [NUM_PORTS-1:0] application_channel_live,
    input wire [NUM_PORTS-1:0] out_of_frame_live,
    input wire [NUM_PORTS-1:0] m_bit_error_pulse,
    input wire [NUM_PORTS-1:0] f_bit_error_pulse,
    input wire [NUM_PORTS-1:0] m23_mode,
    input wire [2*NUM_PORTS-1:0] framing_error_type_select,
    input wire [NUM_PORTS-1:0] format_mismatch_live,
    input wire [NUM_PORTS-1:0] framing_event,
    input wire [NUM_PORTS-1:0] port_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire [1:0] sel = framing_error_type_select[1:0];
    a_fmt_level: assert property (
        format_mismatch_live == ~(m23_mode ^ application_channel_live)) else $error("mismatch level");
    a_fsel_event: assert property (
        $past(aresetn) |-> framing_event[0] == (sel == 2'b01 ? m_bit_error_pulse[0] |
        f_bit_error_pulse[0] : sel == 2'b10 ? f_bit_error_pulse[0] : sel == 2'b11 ?
        m_bit_error_pulse[0] : out_of_frame_live[0] & !$past(out_of_frame_live[0])))
        else $error("framing event select");
    a_reset_clean: assert property (
        $rose(aresetn) |-> port_irq == 0 && m23_mode == 0 && framing_error_type_select == 0)
        else $error("state after reset");
    a_irq_sticky: assert property (
        $fell(port_irq[0]) |-> $rose(s_axi_bvalid)) else $error("irq dropped without write");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_aw_refuse: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address slot not held");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
    a_w_refuse: assert property (
        s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("data slot not held");
endmodule // ds3_rx_status_sva

// File: dv/tb_ds3_rx_status_latch_irq.sv
// self-checking bench for the receive status latch block
`timescale 1ns/1ps
`include "ds3_rx_status_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_ds3_rx_status_latch_irq;
    localparam [11:0] CTL = {4'h0, `IDX_RX_CONTROL, 2'b00};
    localparam [11:0] NZ = {4'h0, `IDX_COUNT_NONZERO, 2'b00};
    localparam [11:0] LA = {4'h0, `IDX_LATCH_A, 2'b00};
    localparam [11:0] LB = {4'h0, `IDX_LATCH_B, 2'b00};
    localparam [11:0] EA = {4'h0, `IDX_IRQ_EN_A, 2'b00};
    localparam [11:0] EB = {4'h0, `IDX_IRQ_EN_B, 2'b00};
    localparam [11:0] MODE = {4'h0, `IDX_FRAMER_MODE, 2'b00};
    localparam [11:0] GL = {`BLK_GLOBAL, 8'h00};
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] m23_mode, format_mismatch_live, framing_event, port_irq;
    wire [7:0] framing_error_type_select;
    reg [3:0] lv [0:10];
    reg [3:0] pl [0:5];
    reg [15:0] cnt [0:3];
    wire [3:0] application_channel_live = lv[10], idle_live = lv[9];
    wire [3:0] unframed_all_ones_live = lv[8], multiframe_loss_live = lv[7];
    wire [3:0] severe_frame_error_live = lv[6], frame_loss_live = lv[4];
    wire [3:0] remote_alarm_live = lv[3], alarm_indication_live = lv[2];
    wire [3:0] out_of_frame_live = lv[1], signal_absent_live = lv[0];
    wire [3:0] alignment_reload_new = pl[0], c_parity_error_pulse = pl[1];
    wire [3:0] far_end_block_error_pulse = pl[2], p_parity_error_pulse = pl[3];
    wire [3:0] m_bit_error_pulse = pl[4], f_bit_error_pulse = pl[5];
    wire [63:0] c_parity_count = {48'h0, cnt[3]}, far_end_count = {48'h0, cnt[2]};
    wire [63:0] p_parity_count = {48'h0, cnt[1]}, framing_count = {48'h0, cnt[0]};
    integer errors = 0, samples_checked = 0, cycles = 0, b;
    reg [1:0] resp;
    ds3_rx_status_latch_irq i_ds3_rx_status_latch_irq (.*);
    always #4 aclk = ~aclk;
    task conclude;
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task wr(input [11:0] a, input [31:0] d);
        reg [1:0] p;
        p = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (p != 2'b00) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) p[0] = 1'b0;
            if (s_axi_wready === 1'b1) p[1] = 1'b0;
            s_axi_awvalid <= p[0];
            s_axi_wvalid <= p[1];
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [11:0] a, input [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `CHK($sformatf("reg %h", a), e, s_axi_rdata)
    endtask
    task pulse(input integer i);
        @(posedge aclk);
        pl[i] <= 4'h1;
        @(posedge aclk);
        pl[i] <= 4'h0;
    endtask
    task t_reset;
        rd(EA, 0);
        rd(EB, 0);
        rd(LA, 0);
        `CHK("mismatch", 4'hf, format_mismatch_live)
        wr(12'h500, 1);
        `CHK("bresp", `RESP_DECERR, resp)
        rd(12'h500, 0);
        `CHK("rresp", `RESP_DECERR, resp)
    endtask
    task t_toggle;
        for (b = 0; b < 11; b++) begin
            if (b != 5) begin
                lv[b] <= 4'h1;
                rd(LA, 1 << b);
                wr(LA, 0);
                rd(LA, 1 << b);
                wr(LA, 32'hffff);
                rd(LA, 0);
                lv[b] <= 4'h0;
                rd(LA, (1 << b) | (b == 10 ? 32'h800 : 0));
                wr(LA, 32'hffff);
            end
        end
    endtask
    task t_errors;
        wr(LB, 32'hffff);
        pulse(0);
        rd(LA, 32'h20);
        for (b = 1; b < 4; b++) begin
            pulse(b);
            rd(LB, 32'h1000 >> b);
            wr(LB, 32'hffff);
        end
        wr(MODE, 1);
        `CHK("m23", 4'h1, m23_mode)
        `CHK("mismatch", 4'he, format_mismatch_live)
        cnt[3] <= 16'h1;
        cnt[2] <= 16'h1;
        pulse(1);
        pulse(2);
        pulse(3);
        rd(NZ, 0);
        rd(LB, 32'h200);
        cnt[3] <= 16'h0;
        cnt[2] <= 16'h0;
        wr(MODE, 0);
        wr(LB, 32'hffff);
    endtask
    task t_framing;
        for (b = 0; b < 4; b++) begin
            wr(CTL, b << 8);
            rd(CTL, b << 8);
            `CHK("fsel", b[1:0], framing_error_type_select[1:0])
            pulse(4);
            rd(LB, b[0] ? 32'h100 : 0);
            wr(LB, 32'hffff);
            pulse(5);
            rd(LB, (b == 1 || b == 2) ? 32'h100 : 0);
            wr(LB, 32'hffff);
            lv[1] <= 4'h1;
            rd(LB, b == 0 ? 32'h100 : 0);
            lv[1] <= 4'h0;
            wr(LB, 32'hffff);
        end
    endtask
    task t_counts;
        for (b = 0; b < 4; b++) begin
            cnt[b] <= 16'h1 << (b * 5);
            rd(NZ, 1 << b);
            rd(LB, 1 << b);
            cnt[b] <= 16'h0;
            wr(LB, 32'hffff);
        end
    endtask
    task t_irq;
        wr(LA, 32'hffff);
        pulse(0);
        wr(EA, 32'h20);
        `CHK("irq", 4'h0, port_irq)
        wr(GL, 1);
        `CHK("irq", 4'h1, port_irq)
        wr(EA, 0);
        `CHK("irq", 4'h0, port_irq)
        wr(EA, 32'h20);
        wr(LA, 32'hffdf);
        `CHK("irq", 4'h1, port_irq)
        wr(LA, 32'hffff);
        `CHK("irq", 4'h0, port_irq)
        wr(EB, 32'h801);
        pulse(1);
        rd(EB, 32'h801);
        `CHK("irq", 4'h1, port_irq)
        cnt[0] <= 16'h1;
        wr(LB, 32'h800);
        `CHK("irq", 4'h1, port_irq)
        cnt[0] <= 16'h0;
        wr(LB, 32'h1);
        `CHK("irq", 4'h0, port_irq)
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            conclude;
        end
    end
    initial begin
        for (b = 0; b < 11; b++) lv[b] = 4'h0;
        for (b = 0; b < 6; b++) pl[b] = 4'h0;
        for (b = 0; b < 4; b++) cnt[b] = 16'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_toggle;
        t_errors;
        t_framing;
        t_counts;
        t_irq;
        conclude;
    end
endmodule // tb_ds3_rx_status_latch_irq
bind ds3_rx_status_latch_irq ds3_rx_status_sva #(.NUM_PORTS(NUM_PORTS)) i_ds3_rx_status_sva (.*);
